/* verilog/ssi_encoder_slave.sv */
// encoder emulation end of the ssi link: answers a master's clock bursts
// with the absolute position, shifted out msb first.
// assumes the link clock is asynchronous to I_CLK and much slower than it.
`timescale 1ns/1ps
`default_nettype none
module ssi_encoder_slave
  import ssi_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_POS_VALID,
  input wire logic [TURNS_W-1:0] I_POS_TURNS,
  input wire logic [ANGLE_W-1:0] I_POS_ANGLE,
  output logic O_POS_READY,
  input wire logic [1:0] I_REG_ADDR,
  input wire logic I_REG_WRITE,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  output logic O_FRAME_ACTIVE,
  ssi_link_if.slave link
);
  typedef enum logic [1:0] {SL_ARMED, SL_FRAME, SL_TAIL} slave_state_e;

  slave_state_e state_q;
  slave_state_e state_d;
  logic [7:0] layout_q;
  logic [7:0] config_q;
  logic [TURNS_W+ANGLE_W-1:0] pos_q;
  logic [WORD_W-1:0] shreg_q;
  logic [5:0] cnt_q;
  logic [5:0] pulses_q;
  logic late_q;
  logic [CNT_W-1:0] idle_cnt_q;
  logic sclk_s1_q;
  logic sclk_s2_q;
  logic sclk_s3_q;
  logic data_q;
  logic abort_q;
  logic active_q;
  logic [7:0] rdata_q;
  logic buf_valid;
  logic [TURNS_W+ANGLE_W-1:0] buf_data;

  // the position source is stalled during a frame, so the buffer really fills
  wire buf_take = (state_q == SL_ARMED);
  wire pos_load = buf_valid && buf_take;

  ssi_pos_buffer #(
    .W(TURNS_W + ANGLE_W),
    .DEPTH(2)
  ) u_pos_buffer (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_valid(I_POS_VALID),
    .i_data({I_POS_TURNS, I_POS_ANGLE}),
    .o_ready(O_POS_READY),
    .o_valid(buf_valid),
    .o_data(buf_data),
    .i_ready(buf_take)
  );

  // link clock edge detection on the synchronised copy only
  wire idle_lvl = config_q[CFG_IDLE_BIT];
  wire sclk_chg = sclk_s2_q ^ sclk_s3_q;
  wire first_edge = sclk_chg && (sclk_s3_q == idle_lvl);
  wire second_edge = sclk_chg && (sclk_s2_q == idle_lvl);
  wire timeout = (idle_cnt_q == CNT_W'(TIMEOUT_CYC));

  // frame layout and coding are frozen at capture
  wire [2:0] lay_idx = layout_index(layout_q);
  wire lay_bad = (layout_q >= 8'(LAYOUT_COUNT));
  wire [WORD_W-1:0] live_word = pack_word(lay_idx, pos_q[TURNS_W+ANGLE_W-1:ANGLE_W],
                                          pos_q[ANGLE_W-1:0], config_q[CFG_GRAY_BIT]);
  wire [5:0] live_pulses = 6'(PULSES[lay_idx]);

  wire capture = (state_q == SL_ARMED) && first_edge;
  wire in_frame = (state_q == SL_FRAME);
  // early mode moves data on the first edge of pulses 2..n, late mode on
  // the second edge of pulses 1..n-1; either way n-1 bits leave
  wire shift_now = in_frame && (late_q ? (second_edge && (cnt_q < pulses_q)) : first_edge);
  wire end_now = in_frame && second_edge && (cnt_q == pulses_q);
  wire abort_now = in_frame && timeout;
  wire abort_clr = I_REG_WRITE && (I_REG_ADDR == SLV_REG_STATUS) && I_REG_WDATA[STS_ABORT_BIT];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SL_ARMED: begin
        if (first_edge) begin
          state_d = SL_FRAME;
        end
      end
      SL_FRAME: begin
        if (timeout) begin
          state_d = SL_ARMED;
        end else if (end_now) begin
          state_d = SL_TAIL;
        end
      end
      SL_TAIL: begin
        // stray pulses after the frame are ignored until the clock rests
        if (timeout) begin
          state_d = SL_ARMED;
        end
      end
    endcase
  end

  wire [7:0] status_word = {5'h00, lay_bad, abort_q, active_q};
  wire [7:0] rd_mux = (I_REG_ADDR == SLV_REG_LAYOUT) ? layout_q :
                      (I_REG_ADDR == SLV_REG_CONFIG) ? config_q :
                      (I_REG_ADDR == SLV_REG_STATUS) ? status_word : 8'h00;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
    end else begin
      // the link clock is only ever read, never driven from this end
      sclk_s1_q <= link.sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      layout_q <= SLV_LAYOUT_RESET;
      config_q <= SLV_CONFIG_RESET;
      rdata_q <= 8'h00;
    end else begin
      if (I_REG_WRITE && (I_REG_ADDR == SLV_REG_LAYOUT)) begin
        layout_q <= I_REG_WDATA;
      end
      if (I_REG_WRITE && (I_REG_ADDR == SLV_REG_CONFIG)) begin
        config_q <= I_REG_WDATA;
      end
      rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      idle_cnt_q <= '0;
    end else if (sclk_chg) begin
      idle_cnt_q <= '0;
    end else if (!timeout) begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pos_q <= '0;
    end else if (pos_load) begin
      pos_q <= buf_data;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= SL_ARMED;
      shreg_q <= '0;
      cnt_q <= '0;
      pulses_q <= '0;
      late_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (capture) begin
        shreg_q <= live_word;
        cnt_q <= 6'h01;
        pulses_q <= live_pulses;
        late_q <= config_q[CFG_LATE_BIT];
      end else if (shift_now) begin
        shreg_q <= shreg_q << 1;
      end
      if (in_frame && first_edge) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      data_q <= DATA_IDLE;
    end else if (end_now || abort_now || (state_q == SL_ARMED)) begin
      data_q <= DATA_IDLE;
    end else if (shift_now) begin
      data_q <= shreg_q[WORD_W-1];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      abort_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      // a new abort in the same cycle as its clear is kept
      abort_q <= abort_now || (abort_q && !abort_clr);
      active_q <= (state_d != SL_ARMED);
    end
  end

  assign link.data = data_q;
  assign O_REG_RDATA = rdata_q;
  assign O_FRAME_ACTIVE = active_q;
endmodule // ssi_encoder_slave
`default_nettype wire

/* verilog/ssi_pkg.sv */
// shared constants, frame layouts and word helpers for the ssi encoder link
// assumes a 200 mhz system clock on both ends of the link
package ssi_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TURNS_W = 12;
  localparam int unsigned ANGLE_W = 20;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned CNT_W = 13;
  localparam int unsigned LAYOUT_COUNT = 5;
  localparam logic [7:0] LAYOUT_TWELVE_TWELVE = 8'h00;
  localparam logic [7:0] LAYOUT_EIGHT_SIXTEEN = 8'h01;
  localparam logic [7:0] LAYOUT_TEN_TWENTY = 8'h02;
  localparam logic [7:0] LAYOUT_TWENTYFIVE_BIT = 8'h03;
  localparam logic [7:0] LAYOUT_TWENTYTHREE_BIT = 8'h04;
  localparam int unsigned MT_BITS [LAYOUT_COUNT] = '{12, 8, 10, 12, 10};
  localparam int unsigned ST_BITS [LAYOUT_COUNT] = '{12, 16, 20, 13, 13};
  localparam int unsigned PULSES [LAYOUT_COUNT] = '{25, 25, 31, 26, 24};
  // ssi_link_config fields
  localparam int unsigned CFG_RATE_LSB = 0;
  localparam int unsigned CFG_IDLE_BIT = 2;
  localparam int unsigned CFG_LATE_BIT = 3;
  localparam int unsigned CFG_GRAY_BIT = 4;
  localparam int unsigned BAUD_0 = 201_600;
  localparam int unsigned BAUD_1 = 500_000;
  localparam int unsigned BAUD_2 = 1_042_000;
  localparam int unsigned BAUD_3 = 1_560_000;
  localparam int unsigned HALF_CYC [4] = '{CLK_HZ / (2 * BAUD_0), CLK_HZ / (2 * BAUD_1),
                                          CLK_HZ / (2 * BAUD_2), CLK_HZ / (2 * BAUD_3)};
  // clock held idle this long ends a frame on the slave
  localparam int unsigned TIMEOUT_NS = 20_000;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned PAUSE_MARGIN_CYC = 64;
  localparam logic DATA_IDLE = 1'b1;
  // device register indices and status bits
  localparam logic [1:0] SLV_REG_LAYOUT = 2'h0;
  localparam logic [1:0] SLV_REG_CONFIG = 2'h1;
  localparam logic [1:0] SLV_REG_STATUS = 2'h2;
  localparam logic [7:0] SLV_LAYOUT_RESET = 8'h00;
  localparam logic [7:0] SLV_CONFIG_RESET = 8'h00;
  localparam int unsigned STS_ACTIVE_BIT = 0;
  localparam int unsigned STS_ABORT_BIT = 1;
  localparam int unsigned STS_BADLAY_BIT = 2;
  // controller registers, word addressed
  localparam logic [1:0] MST_REG_CTRL = 2'h0;
  localparam logic [1:0] MST_REG_STATUS = 2'h1;
  localparam logic [1:0] MST_REG_TURNS = 2'h2;
  localparam logic [1:0] MST_REG_ANGLE = 2'h3;
  localparam int unsigned CTRL_LAYOUT_LSB = 0;
  localparam int unsigned CTRL_CONFIG_LSB = 8;
  localparam int unsigned CTRL_START_BIT = 16;
  localparam int unsigned MSTS_DONE_BIT = 0;
  localparam int unsigned MSTS_BUSY_BIT = 1;

  function automatic logic [2:0] layout_index(input logic [7:0] code);
    return (code < 8'(LAYOUT_COUNT)) ? code[2:0] : 3'h0;
  endfunction

  function automatic logic [WORD_W-1:0] field_mask(input int unsigned bits);
    return (32'h1 << bits) - 32'h1;
  endfunction

  function automatic logic [WORD_W-1:0] gray_to_bin(input logic [WORD_W-1:0] g);
    logic [WORD_W-1:0] b;
    b[WORD_W-1] = g[WORD_W-1];
    for (int i = WORD_W - 2; i >= 0; i--) begin
      b[i] = g[i] ^ b[i+1];
    end
    return b;
  endfunction

  // multi-turn above single-turn, coded, then pushed up so the msb sits at the top
  function automatic logic [WORD_W-1:0] pack_word(input logic [2:0] idx,
      input logic [TURNS_W-1:0] turns, input logic [ANGLE_W-1:0] angle, input logic gray);
    logic [WORD_W-1:0] v;
    int unsigned m;
    int unsigned s;
    m = MT_BITS[idx];
    s = ST_BITS[idx];
    v = ((32'(turns) & field_mask(m)) << s) | (32'(angle) & field_mask(s));
    if (gray) begin
      v = v ^ (v >> 1);
    end
    return v << (WORD_W - m - s);
  endfunction
endpackage

/* verilog/ssi_link_if.sv */
// the two wires of the ssi link between controller and encoder emulation
// assumes the bench resolves nothing: each wire has exactly one driver
`timescale 1ns/1ps
`default_nettype none
interface ssi_link_if;
  logic sclk;
  logic data;
  modport master (output sclk, input data);
  modport slave (input sclk, output data);
endinterface
`default_nettype wire

/* verilog/ssi_pos_buffer.sv */
// small fifo for position words with valid/ready on both sides
// assumes one clock and an async active-low reset
`timescale 1ns/1ps
`default_nettype none
module ssi_pos_buffer #(
  parameter int unsigned W = 32,
  parameter int unsigned DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic ready_q;
  wire push = i_valid && ready_q;
  wire pop = o_valid && i_ready;
  wire [AW-1:0] wr_next = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
  wire [AW-1:0] rd_next = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;

  assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
  assign o_valid = (count_q != '0);
  assign o_data = mem_q[rd_ptr_q];
  assign o_ready = ready_q;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ready_q <= 1'b0;
    end else begin
      wr_ptr_q <= push ? wr_next : wr_ptr_q;
      rd_ptr_q <= pop ? rd_next : rd_ptr_q;
      count_q <= count_d;
      // ready is registered so the source sees it straight from a flop
      ready_q <= (count_d != (AW+1)'(DEPTH));
    end
  end
endmodule // ssi_pos_buffer
`default_nettype wire

/* verilog/ssi_encoder_master.sv */
// controller end of the ssi link: makes the clock burst and gathers the word.
// assumes software on avalon-mm; the link data pin is asynchronous to I_CLK.
`timescale 1ns/1ps
`default_nettype none
module ssi_encoder_master
  import ssi_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  ssi_link_if.master link
);
  typedef enum logic [1:0] {M_IDLE, M_RUN, M_PAUSE} master_state_e;

  master_state_e state_q;
  logic [7:0] layout_q;
  logic [7:0] config_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic done_q;
  logic [TURNS_W-1:0] turns_q;
  logic [ANGLE_W-1:0] angle_q;
  logic sclk_q;
  logic [9:0] div_q;
  logic [6:0] edge_q;
  logic [CNT_W-1:0] pause_q;
  logic [WORD_W-1:0] rx_q;
  logic data_s1_q;
  logic data_s2_q;

  wire req = I_AVS_READ || I_AVS_WRITE;
  wire accept = req && !wait_q;
  wire busy = (state_q != M_IDLE);
  wire ctrl_wr = accept && I_AVS_WRITE && (I_AVS_ADDRESS == MST_REG_CTRL) && !busy;
  wire start = ctrl_wr && I_AVS_WRITEDATA[CTRL_START_BIT];

  wire [2:0] lay_idx = layout_index(layout_q);
  wire [6:0] last_edge = 7'(2 * PULSES[lay_idx] - 1);
  wire [9:0] half = 10'(HALF_CYC[config_q[CFG_RATE_LSB +: 2]]);
  // a start also rewrites the setting: its first half and idle level must already
  // follow the new word, or an idle-level change turns into a false leading edge
  wire [7:0] start_cfg = I_AVS_WRITEDATA[CTRL_CONFIG_LSB +: 8];
  wire [9:0] start_half = 10'(HALF_CYC[start_cfg[CFG_RATE_LSB +: 2]]);
  wire idle_next = start ? start_cfg[CFG_IDLE_BIT] : config_q[CFG_IDLE_BIT];
  wire tick = (state_q == M_RUN) && (div_q == '0);
  // the leading pulse carries no data; bits are read from pulse 2 on
  wire sample = tick && (edge_q >= 7'h02) &&
                (config_q[CFG_LATE_BIT] ? !edge_q[0] : edge_q[0]);
  wire run_end = tick && (edge_q == last_edge);
  wire pause_end = (state_q == M_PAUSE) && (pause_q == '0);

  wire [WORD_W-1:0] word = config_q[CFG_GRAY_BIT] ? gray_to_bin(rx_q) : rx_q;
  wire [WORD_W-1:0] turns_w = (word >> ST_BITS[lay_idx]) & field_mask(MT_BITS[lay_idx]);
  wire [WORD_W-1:0] angle_w = word & field_mask(ST_BITS[lay_idx]);
  wire [31:0] status_word = {30'h0, busy, done_q};
  wire [31:0] rd_mux = (I_AVS_ADDRESS == MST_REG_CTRL) ? {16'h0, config_q, layout_q} :
                       (I_AVS_ADDRESS == MST_REG_STATUS) ? status_word :
                       (I_AVS_ADDRESS == MST_REG_TURNS) ? 32'(turns_q) : 32'(angle_q);

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      // one wait cycle per access, then waitrequest drops for one edge
      wait_q <= !(req && wait_q);
      if (I_AVS_READ && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      layout_q <= LAYOUT_TWELVE_TWELVE;
      config_q <= 8'h00;
    end else if (ctrl_wr) begin
      layout_q <= I_AVS_WRITEDATA[CTRL_LAYOUT_LSB +: 8];
      config_q <= I_AVS_WRITEDATA[CTRL_CONFIG_LSB +: 8];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      data_s1_q <= DATA_IDLE;
      data_s2_q <= DATA_IDLE;
    end else begin
      data_s1_q <= link.data;
      data_s2_q <= data_s1_q;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= M_IDLE;
      sclk_q <= 1'b0;
      div_q <= '0;
      edge_q <= '0;
      pause_q <= '0;
    end else begin
      unique case (state_q)
        M_IDLE: begin
          sclk_q <= idle_next;
          if (start) begin
            state_q <= M_RUN;
            div_q <= start_half - 10'h001;
            edge_q <= '0;
          end
        end
        M_RUN: begin
          div_q <= tick ? half - 10'h001 : div_q - 10'h001;
          if (tick) begin
            sclk_q <= !sclk_q;
            edge_q <= edge_q + 7'h01;
          end
          if (run_end) begin
            state_q <= M_PAUSE;
            pause_q <= CNT_W'(TIMEOUT_CYC + PAUSE_MARGIN_CYC);
          end
        end
        M_PAUSE: begin
          // clock rests past the slave's timeout before the next frame
          pause_q <= pause_q - 1'b1;
          if (pause_end) begin
            state_q <= M_IDLE;
          end
        end
        default: begin
          state_q <= M_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rx_q <= '0;
      done_q <= 1'b0;
      turns_q <= '0;
      angle_q <= '0;
    end else begin
      if (start) begin
        rx_q <= '0;
      end else if (sample) begin
        rx_q <= {rx_q[WORD_W-2:0], data_s2_q};
      end
      if (pause_end) begin
        turns_q <= turns_w[TURNS_W-1:0];
        angle_q <= angle_w[ANGLE_W-1:0];
      end
      // completion wins over a start in the same cycle
      done_q <= pause_end || (done_q && !start);
    end
  end

  assign link.sclk = sclk_q;
  assign O_AVS_READDATA = rdata_q;
  assign O_AVS_WAITREQUEST = wait_q;
endmodule // ssi_encoder_master
`default_nettype wire

/* sim/ssi_link_sva.sv */
// concurrent checks on the two ssi link wires between controller and encoder emulation
// assumes the bench top feeds the system clock, its reset and both link wires
`timescale 1ns/1ps
`default_nettype none
module ssi_link_sva
  import ssi_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic sclk,
  input wire logic data
);
  // longer than the slowest half period, shorter than the re-arm timeout
  localparam int GAP = 600;
  logic sclk_prev_q;
  logic long_q;
  logic [CNT_W-1:0] run_q;
  wire edge_w = sclk != sclk_prev_q;
  wire [CNT_W-1:0] run_d = edge_w ? '0 : (&run_q ? run_q : run_q + 1'b1);
  wire long_d = edge_w ? (run_q >= GAP) : long_q;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sclk_prev_q <= 1'b0;
      run_q <= '0;
      long_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk;
      run_q <= run_d;
      long_q <= long_d;
    end
  end

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  // the first edge after a long rest has no half period to measure against
  property p_half_period;
    edge_w && !long_q && run_q < GAP |->
      (run_q + 1) inside {HALF_CYC[0], HALF_CYC[1], HALF_CYC[2], HALF_CYC[3]};
  endproperty
  a_half_period: assert property (p_half_period) else $error("link clock half period off");
  property p_frame_gap;
    edge_w && run_q >= GAP |-> run_q >= TIMEOUT_CYC;
  endproperty
  a_frame_gap: assert property (p_frame_gap) else $error("frame started before timeout");
  property p_data_after_edge;
    $changed(data) |-> run_q inside {[1:10]};
  endproperty
  a_data_after_edge: assert property (p_data_after_edge) else $error("data moved off edge");
  property p_data_idle;
    run_q >= GAP |-> data;
  endproperty
  a_data_idle: assert property (p_data_idle) else $error("data not idle high");
  property p_frame_start;
    edge_w && run_q >= GAP |-> data [*8];
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("leading pulse moved data");
  property p_bit_hold;
    $changed(data) |=> $stable(data) [*8];
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("data bit too short");
  property p_reset_clock;
    $rose(I_RST_N) |-> !sclk [*8];
  endproperty
  a_reset_clock: assert property (p_reset_clock) else $error("clock not idle low");
  property p_reset_data;
    $rose(I_RST_N) |-> data [*8];
  endproperty
  a_reset_data: assert property (p_reset_data) else $error("data not high after reset");
endmodule // ssi_link_sva
`default_nettype wire

/* sim/test_ssi_encoder_emulation_slave.sv */
// self-checking bench: controller and encoder emulation joined by one ssi link
// assumes package, link interface, both ends and the link checker compiled first
`timescale 1ns/1ps
`default_nettype none
module test_ssi_encoder_emulation_slave
  import ssi_pkg::*;
;
  logic clk;
  logic rst_n;
  logic [1:0] avs_addr;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_wdata;
  logic [31:0] avs_rdata;
  logic avs_wait;
  logic pos_valid;
  logic [TURNS_W-1:0] pos_turns;
  logic [ANGLE_W-1:0] pos_angle;
  logic pos_ready;
  logic [1:0] reg_addr;
  logic reg_write;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic frame_active;
  int fail_count;
  int n_compared;
  logic idle_lvl;
  logic late;
  logic act_q;
  int pulses;
  logic [31:0] bits;
  logic [7:0] cfgs [5] = '{8'h03, 8'h15, 8'h0E, 8'h1B, 8'h10};
  logic [11:0] turns [5] = '{12'hA5C, 12'hFC3, 12'h3E7, 12'h81F, 12'h2B4};
  logic [19:0] angles [5] = '{20'h5A3C6, 20'hF1E2D, 20'hC3A59, 20'h1FFF0, 20'h17E4B};

  ssi_link_if i_ssi_link_if();
  ssi_encoder_master i_ssi_encoder_master(.I_CLK(clk), .I_RST_N(rst_n),
    .I_AVS_ADDRESS(avs_addr), .I_AVS_READ(avs_read), .I_AVS_WRITE(avs_write),
    .I_AVS_WRITEDATA(avs_wdata), .O_AVS_READDATA(avs_rdata),
    .O_AVS_WAITREQUEST(avs_wait), .link(i_ssi_link_if));
  ssi_encoder_slave i_ssi_encoder_slave(.I_CLK(clk), .I_RST_N(rst_n),
    .I_POS_VALID(pos_valid), .I_POS_TURNS(pos_turns), .I_POS_ANGLE(pos_angle),
    .O_POS_READY(pos_ready), .I_REG_ADDR(reg_addr), .I_REG_WRITE(reg_write),
    .I_REG_WDATA(reg_wdata), .O_REG_RDATA(reg_rdata), .O_FRAME_ACTIVE(frame_active),
    .link(i_ssi_link_if));
  ssi_link_sva i_ssi_link_sva(.I_CLK(clk), .I_RST_N(rst_n), .sclk(i_ssi_link_if.sclk),
    .data(i_ssi_link_if.data));

  always #2.5 clk = ~clk;

  // counts pulses away from idle and gathers data at the reading edge
  always @(posedge clk) begin : wire_watch
    logic act;
    act = i_ssi_link_if.sclk ^ idle_lvl;
    if (act && !act_q) pulses++;
    if (pulses >= 2 && (late ? act && !act_q : !act && act_q)) bits = {bits[30:0], i_ssi_link_if.data};
    act_q = act;
  end

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic [1:0] a, input logic wr, input logic [31:0] wd,
      output logic [31:0] rd);
    int n;
    @(posedge clk);
    avs_addr <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_wdata <= wd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_wait !== 1'b0 && n < 50);
    rd = avs_rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_wait !== 1'b0) begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic sreg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_write <= 1'b1;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'b0;
    repeat (3) @(posedge clk);
    check({24'h0, reg_rdata}, {24'h0, v});
  endtask

  task automatic frame(input int k);
    logic [31:0] r;
    logic [31:0] v;
    int m;
    int s;
    int n;
    m = MT_BITS[k];
    s = ST_BITS[k];
    v = ((32'(turns[k]) & ((32'h1 << m) - 1)) << s) | (32'(angles[k]) & ((32'h1 << s) - 1));
    pos_turns <= turns[k];
    pos_angle <= angles[k];
    sreg(SLV_REG_LAYOUT, 8'(k));
    sreg(SLV_REG_CONFIG, cfgs[k]);
    idle_lvl = cfgs[k][CFG_IDLE_BIT];
    late = cfgs[k][CFG_LATE_BIT];
    act_q = i_ssi_link_if.sclk ^ idle_lvl;
    pulses = 0;
    bits = '0;
    bus(MST_REG_CTRL, 1'b1, {15'h0, 1'b1, cfgs[k], 8'(k)}, r);
    n = 0;
    do begin
      bus(MST_REG_STATUS, 1'b0, 32'h0, r);
      n++;
      // mid-frame the slave holds its word, so the stalled buffer must refuse
      if (n == 300) check({30'h0, pos_ready, frame_active}, 32'h1);
    end while (r[MSTS_DONE_BIT] !== 1'b1 && n < 20000);
    if (r[MSTS_DONE_BIT] !== 1'b1) begin
      fail_count++;
      finish_test();
    end
    check(32'(pulses), PULSES[k]);
    check(bits & ((32'h1 << (m + s)) - 1), cfgs[k][CFG_GRAY_BIT] ? v ^ (v >> 1) : v);
    check({31'h0, i_ssi_link_if.sclk}, {31'h0, idle_lvl});
    bus(MST_REG_TURNS, 1'b0, 32'h0, r);
    check(r, v >> s);
    bus(MST_REG_ANGLE, 1'b0, 32'h0, r);
    check(r, v & ((32'h1 << s) - 1));
    check({31'h0, pos_ready}, 32'h1);
    // after the rest the slave is re-armed with no abort and a valid layout
    reg_addr <= SLV_REG_STATUS;
    repeat (3) @(posedge clk);
    check({24'h0, reg_rdata}, 32'h0);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    avs_addr = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_wdata = 32'h0;
    pos_valid = 1'b0;
    pos_turns = '0;
    pos_angle = '0;
    reg_addr = 2'h0;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    fail_count = 0;
    n_compared = 0;
    idle_lvl = 1'b0;
    late = 1'b0;
    act_q = 1'b0;
    pulses = 0;
    bits = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    pos_valid <= 1'b1;
    // the link checker wants the clock idle past the slave's timeout before the first frame
    repeat (4100) @(posedge clk);
    for (int k = 0; k < 5; k++) begin
      frame(k);
    end
    finish_test();
  end
endmodule // test_ssi_encoder_emulation_slave
`default_nettype wire
